// [tbar_cfg.svh]
// Purpose: Constants for the two-wire bus arbitration block
// Assumes: Included by package and design files
// Notes: Definitions only
`ifndef TBAR_CFG_SVH
`define TBAR_CFG_SVH

// ----------------------------------------
// State encodings
// ----------------------------------------
`define TBAR_ST_RESET 2'h0
`define TBAR_ST_EM_OWN 2'h1
`define TBAR_ST_IMPLICIT 2'h2
`define TBAR_ST_EXPLICIT 2'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TBAR_SYNC_RESET 2'h3
`define TBAR_BUS_DRIVEN_N_RESET 1'h1

`endif

// [tbar_pkg.sv]
// Purpose: Types for the two-wire bus arbitration block
// Assumes: tbar_cfg.svh holds the encodings
// Notes: Nothing is imported by users
`include "tbar_cfg.svh"

package tbar_pkg;

   // ----------------------------------------
   // Arbitration states
   // ----------------------------------------
   typedef enum logic [1:0] {
      TBAR_RESET = `TBAR_ST_RESET,
      TBAR_EM_OWN = `TBAR_ST_EM_OWN,
      TBAR_IMPLICIT = `TBAR_ST_IMPLICIT,
      TBAR_EXPLICIT = `TBAR_ST_EXPLICIT
   } tbar_state_t;

endpackage

// [tbar_sync.sv]
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Asynchronous active-low reset
// Notes: First stage read only by the second
`timescale 1ns/1ns
`include "tbar_cfg.svh"

module tbar_sync (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic d,
   output logic q
);

   logic meta;

   // ----------------------------------------
   // Two stages
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta <= 1'h1;
         q <= 1'h1;
      end else begin
         meta <= d;
         q <= meta;
      end
   end

endmodule

// [tbar_cycle.sv]
// Purpose: Tracks whether a bus access is running
// Assumes: Inputs from same-clock logic
// Notes: A burst-inhibited series is one access
`timescale 1ns/1ns

module tbar_cycle (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clear,
   input wire logic start,
   input wire logic end_of_cycle,
   output logic in_progress
);

   // ----------------------------------------
   // Access tracking
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         in_progress <= 1'h0;
      end else if (clear) begin
         in_progress <= 1'h0;
      end else if (start) begin
         in_progress <= 1'h1;
      end else if (end_of_cycle) begin
         in_progress <= 1'h0;
      end
   end

endmodule

// [tbar_arbiter.sv]
// Purpose: Two-wire bus arbitration state machine, device side
// Assumes: Grant and reset pin are asynchronous; the rest is on clk
// Notes: Bus cycle protocol lives outside; this block grants it
//
// What this block does
// - Transfer may start cycle after grant
// - Unlocked, grant loss: finish cycle, release
// - Burst-inhibited access holds bus-driven till last
// - Locked explicit owner keeps bus without grant
// - Lock cleared, grant off, no access running: release next clock
// - Grant plus request: drive and start access
// - Any reset source forces reset state
// - Leave reset to implicit or external
// - External ownership: never drive bus
// - Implicit ownership: owned but three-stated
// - Implicit moves on request, lock, grant loss
// - Explicit ownership drives bus, bus-driven low
// - Grant held keeps explicit ownership
// - Grant lost unlocked: leave at cycle end
// - Any termination, error too, ends cycle
// - State changes on rising clock, or at once when rst_b goes low
`timescale 1ns/1ns
`include "tbar_cfg.svh"

module tbar_arbiter (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic bus_grant_n,
   input wire logic reset_input_n,
   input wire logic watchdog_reset,
   input wire logic bus_lock_bit,
   input wire logic int_request,
   input wire logic end_of_cycle,
   output logic bus_driven_n,
   output logic bus_drive_en,
   output logic start_ok,
   output logic transfer_active,
   output logic [1:0] arb_state
);

   tbar_pkg::tbar_state_t state;
   tbar_pkg::tbar_state_t next_state;
   logic grant_n_s;
   logic reset_input_n_n_s;
   logic grant;
   logic any_reset;
   logic in_progress;
   logic access_start;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   tbar_sync u_sync_grant (
      .clk(clk),
      .rst_b(rst_b),
      .d(bus_grant_n),
      .q(grant_n_s)
   );

   tbar_sync u_sync_reset_input_n (
      .clk(clk),
      .rst_b(rst_b),
      .d(reset_input_n),
      .q(reset_input_n_n_s)
   );

   assign grant = !grant_n_s;
   assign any_reset = !reset_input_n_n_s || watchdog_reset;

   // ----------------------------------------
   // Access tracking
   // ----------------------------------------
   // Access begins once explicit ownership with a pending request
   assign access_start = (next_state == tbar_pkg::TBAR_EXPLICIT)
      && int_request && !in_progress;

   tbar_cycle u_cycle (
      .clk(clk),
      .rst_b(rst_b),
      .clear(any_reset),
      .start(access_start),
      .end_of_cycle(end_of_cycle),
      .in_progress(in_progress)
   );

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_state = state;
      if (any_reset) begin
         next_state = tbar_pkg::TBAR_RESET;
      end else begin
         unique case (state)
            tbar_pkg::TBAR_RESET: begin
               next_state = grant ? tbar_pkg::TBAR_IMPLICIT
                  : tbar_pkg::TBAR_EM_OWN;
            end
            tbar_pkg::TBAR_EM_OWN, tbar_pkg::TBAR_IMPLICIT: begin
               if (!grant) begin
                  next_state = tbar_pkg::TBAR_EM_OWN;
               end else if (bus_lock_bit || int_request) begin
                  next_state = tbar_pkg::TBAR_EXPLICIT;
               end else begin
                  next_state = tbar_pkg::TBAR_IMPLICIT;
               end
            end
            tbar_pkg::TBAR_EXPLICIT: begin
               if (grant) begin
                  next_state = tbar_pkg::TBAR_EXPLICIT;
               end else if (bus_lock_bit) begin
                  next_state = tbar_pkg::TBAR_EXPLICIT;
               end else if (!in_progress || end_of_cycle) begin
                  next_state = tbar_pkg::TBAR_EM_OWN;
               end else begin
                  next_state = tbar_pkg::TBAR_EXPLICIT;
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= tbar_pkg::TBAR_RESET;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------
   // Outputs from flip-flops
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bus_driven_n <= `TBAR_BUS_DRIVEN_N_RESET;
         bus_drive_en <= 1'h0;
         start_ok <= 1'h0;
         transfer_active <= 1'h0;
         arb_state <= `TBAR_ST_RESET;
      end else begin
         // Only explicit ownership drives; others three-state
         bus_driven_n <= (next_state != tbar_pkg::TBAR_EXPLICIT);
         bus_drive_en <= (next_state == tbar_pkg::TBAR_EXPLICIT);
         start_ok <= access_start;
         transfer_active <= access_start || (in_progress && !end_of_cycle && !any_reset);
         arb_state <= next_state;
      end
   end

endmodule

// [tbar_arbiter_chk.sv]
// Purpose: Checker for the arbitration block ports
// Assumes: Grant seen two edges after the pin
// Notes: Bound to every arbiter instance
`timescale 1ns/1ns
module tbar_arbiter_chk (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic bus_grant_n,
   input wire logic reset_input_n,
   input wire logic watchdog_reset,
   input wire logic bus_lock_bit,
   input wire logic int_request,
   input wire logic end_of_cycle,
   input wire logic bus_driven_n,
   input wire logic bus_drive_en,
   input wire logic start_ok,
   input wire logic transfer_active,
   input wire logic [1:0] arb_state
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_drive_map: assert property ((arb_state == 2'h3) == (!bus_driven_n && bus_drive_en))
      else $error("drive outputs disagree with state");
   a_wdog_reset: assert property (watchdog_reset |=> arb_state == 2'h0)
      else $error("watchdog did not force reset state");
   a_lock_hold: assert property (arb_state == 2'h3 && bus_lock_bit && !watchdog_reset
      |=> arb_state inside {2'h0, 2'h3})
      else $error("locked owner released bus");
   a_unlock_rel: assert property (arb_state == 2'h3 && !bus_lock_bit
      && !transfer_active && $past(bus_grant_n) && bus_grant_n |=> bus_driven_n)
      else $error("bus not released after unlock");
   a_end_rel: assert property (transfer_active && end_of_cycle && !bus_lock_bit
      && $past(bus_grant_n) && bus_grant_n |=> bus_driven_n && !transfer_active)
      else $error("bus kept after cycle end");
   a_burst_hold: assert property (transfer_active && !end_of_cycle && !watchdog_reset
      |=> !bus_driven_n || arb_state == 2'h0)
      else $error("bus dropped mid access");
   a_req_start: assert property (arb_state == 2'h2 && int_request
      && !$past(bus_grant_n) && !bus_grant_n && !watchdog_reset
      |=> start_ok || arb_state == 2'h0)
      else $error("request did not start access");
   a_em_stay: assert property (arb_state == 2'h1 && $past(bus_grant_n) && bus_grant_n
      |=> arb_state inside {2'h0, 2'h1})
      else $error("left external ownership without grant");
   a_start_pulse: assert property (start_ok |=> !start_ok)
      else $error("access start held over two cycles");
   c_start: cover property (start_ok);
   c_lock: cover property (arb_state == 2'h3 && bus_lock_bit && bus_grant_n);
   c_eoc: cover property (transfer_active && end_of_cycle);
endmodule
bind tbar_arbiter tbar_arbiter_chk i_chk (.*);

// [tbar_ext_master.sv]
// Purpose: Far bus master holding the grant line
// Assumes: want high means it needs the bus
// Notes: Behavioural
`timescale 1ns/1ns
module tbar_ext_master (
   input wire logic clk,
   input wire logic want,
   output logic bus_grant_n
);
   initial bus_grant_n = 1'h1;
   // Grant only changes on an edge, following want one clock later
   always @(posedge clk) begin
      bus_grant_n <= want;
   end
endmodule

// [two_wire_bus_arbitration_test.sv]
// Purpose: Self-checking bench for the arbiter
// Assumes: Inputs change 1 ns after the edge
// Notes: Grant comes from the far master model
`timescale 1ns/1ns
module two_wire_bus_arbitration_test;
   logic clk = 1'h0, rst_b = 1'h0, want = 1'h0, rin_n = 1'h1, wd = 1'h0;
   logic lock = 1'h0, req = 1'h0, eoc = 1'h0, grant_n;
   logic drv_n, drv_en, start_ok, active;
   logic [1:0] st;
   int bad_count = 0, n_compared = 0, cyc = 0, i;
   tbar_ext_master i_em (.clk(clk), .want(want), .bus_grant_n(grant_n));
   tbar_arbiter i_dut (.clk(clk), .rst_b(rst_b), .bus_grant_n(grant_n),
      .reset_input_n(rin_n), .watchdog_reset(wd), .bus_lock_bit(lock), .int_request(req),
      .end_of_cycle(eoc), .bus_driven_n(drv_n), .bus_drive_en(drv_en), .start_ok(start_ok),
      .transfer_active(active), .arb_state(st));
   initial forever #4 clk = ~clk;
   always @(posedge clk) if (++cyc == 2000) begin
      bad_count++;
      conclude();
   end
   task automatic conclude();
      if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input bit ok);
      n_compared++;
      if (!ok) begin
         bad_count++;
         $display("CHECK FAILED at %0t: output mismatch", $time);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic t_reset_exit();
      tick(5);
      check(st === 2'h2 && drv_n === 1'h1 && drv_en === 1'h0);
   endtask
   task automatic t_request_burst();
      req = 1'h1;
      for (i = 0; i < 10 && start_ok !== 1'h1; i++) tick(1);
      check(drv_n === 1'h0 && st === 2'h3 && drv_en === 1'h1 && active === 1'h1);
      req = 1'h0;
      want = 1'h1;
      tick(1);
      check(start_ok === 1'h0);
      tick(5);
      check(drv_n === 1'h0 && active === 1'h1);
      eoc = 1'h1;
      tick(1);
      eoc = 1'h0;
      check(st === 2'h1 && drv_n === 1'h1 && drv_en === 1'h0 && active === 1'h0);
   endtask
   task automatic t_lock();
      want = 1'h0;
      tick(5);
      check(st === 2'h2);
      lock = 1'h1;
      tick(1);
      check(st === 2'h3 && drv_n === 1'h0 && drv_en === 1'h1 && start_ok === 1'h0);
      want = 1'h1;
      tick(6);
      check(st === 2'h3 && drv_n === 1'h0);
      lock = 1'h0;
      tick(1);
      check(drv_n === 1'h1 && drv_en === 1'h0 && st === 2'h1);
   endtask
   task automatic t_resets();
      wd = 1'h1;
      tick(1);
      check(st === 2'h0);
      wd = 1'h0;
      tick(1);
      check(st === 2'h1 && drv_n === 1'h1);
      rin_n = 1'h0;
      tick(4);
      check(st === 2'h0 && drv_n === 1'h1);
      rin_n = 1'h1;
      want = 1'h0;
      tick(5);
      check(st === 2'h2);
   endtask
   initial begin
      tick(8);
      rst_b = 1'h1;
      t_reset_exit();
      t_request_burst();
      t_lock();
      t_resets();
      conclude();
   end
endmodule
